// file: core/dac_if_pkg.sv
/*
 * Shared constants and types for the converter programming interface:
 * target address layout, byte sequencing, SPI frame length, state codes.
 * Assumes a SystemVerilog-2012 tool; no clocks or resets are used here.
 */
package dac_if_pkg;

   // ---------------------------------------------------------------
   // target addressing
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_FIXED_HI = 4'h9;
   localparam logic [6:0] BCAST_ADDR = 7'h47;
   localparam logic [6:0] GCALL_ADDR = 7'h00;
   localparam logic [7:0] GCALL_RESET_CMD = 8'h06;
   localparam logic [2:0] SEL_GND = 3'h0;
   localparam logic [2:0] SEL_VDD = 3'h1;
   localparam logic [2:0] SEL_SDA = 3'h2;
   localparam logic [2:0] SEL_SCL = 3'h3;

   // ---------------------------------------------------------------
   // byte sequencing
   // ---------------------------------------------------------------
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] BYTE_CMD = 2'h0;
   localparam logic [1:0] BYTE_UPPER = 2'h1;
   localparam logic [1:0] BYTE_LOWER = 2'h2;
   localparam logic [1:0] BYTE_EXTRA = 2'h3;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ---------------------------------------------------------------
   // spi frame
   // ---------------------------------------------------------------
   localparam int SPI_FRAME_BITS = 24;
   localparam logic [4:0] SPI_POS_LAST = 5'h17;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] upper_data_byte;
      logic [7:0] lower_data_byte;
   } reg_write_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
      ST_RD_BYTE, ST_RD_ACK, ST_RD_NEXT, ST_IGNORE
   } i2c_state_t;

endpackage

// file: core/dac_serial_if.sv
/*
 * I2C target and SPI daisy-chain frame filter of the converter.
 * Assumes sys_clk at least ten times the I2C bit rate, SPI clock idle
 * while spi_sync_n is high, and a register file that answers rd_cmd.
 */
// Summary of operation
// - chained serial output feeds next device input; output pin must be enabled.
// - frame of whole 24-edge multiples uses only last 24 bits shifted in.
// - frame not a multiple of 24 edges is dropped without effect.
// - seven-bit target addressing only; ten-bit sequences never answered.
// - works at 100k, 400k and 1M bit rates with one protocol.
// - general call 0x00 then 0x06 resets the device; no stop is needed.
// - general call reset fires on rising clock of following acknowledge.
// - acknowledge is data held low over whole ninth clock high phase.
// - start is data falling with clock high; stop is data rising.
// - address acknowledged on ninth clock only when it matches ours, broadcast or general call.
// - direction 0 receives, 1 transmits; receiver acknowledges each byte.
// - stop releases bus and returns to idle awaiting next start.
// - update is address, command, upper and lower byte, 36 clocks.
// - command selects register; write needs both data bytes first.
// - data word commits on falling clock of acknowledge after lower byte.
// - upper four address bits are fixed at 1001.
// - select pin sampled during first byte of each frame and latched.
// - broadcast address 1000111 taken for writes only, never reads.
// - read: command write, repeated start, then upper and lower byte out.
`timescale 1ns/1ns
`default_nettype none
module dac_serial_if
#(
   parameter int SPI_CNT_W = 16
)
(
   // system
   input wire logic sys_clk,
   input wire logic reset,
   // i2c pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic address_select_pin,
   // spi pins
   input wire logic spi_sclk,
   input wire logic spi_sync_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   // configuration
   input wire logic serial_out_enable,
   // register side
   output dac_if_pkg::reg_write_t wr_word,
   output logic wr_commit,
   output logic [7:0] rd_cmd,
   input wire logic [15:0] rd_data,
   output logic soft_reset,
   output logic [2:0] addr_low,
   output logic [23:0] spi_word,
   output logic spi_word_valid
);
   import dac_if_pkg::*;

   localparam logic [SPI_CNT_W-1:0] CNT_ONE = SPI_CNT_W'(1);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic sel_s1, sel_s2, sync_s1, sync_s2, sync_s3;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {sel_s1, sel_s2} <= 2'h0;
         {sync_s1, sync_s2, sync_s3} <= 3'h7;
      end
      else
      begin
         {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
         {sel_s1, sel_s2} <= {address_select_pin, sel_s1};
         {sync_s1, sync_s2, sync_s3} <= {spi_sync_n, sync_s1, sync_s2};
      end
   end

   // oversampling at 10 MHz keeps up with the 1 Mbit/s bus
   logic scl_rise, scl_fall, start, stop;
   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // ------------------------------------------------------------
   // address match
   // ------------------------------------------------------------
   i2c_state_t state_ff, nxt_state;
   logic [2:0] bitcnt_ff, nxt_bitcnt, sel_code_ff, nxt_sel_code, sel_now;
   logic [7:0] shift_ff, nxt_shift, tx_ff, nxt_tx, byte_rx;
   logic [7:0] cmd_ff, nxt_cmd, upper_ff, nxt_upper, lower_ff, nxt_lower;
   logic [1:0] byte_idx_ff, nxt_byte_idx;
   logic gcall_ff, nxt_gcall, bcast_ff, nxt_bcast, rw_ff, nxt_rw;
   logic gc_pend_ff, nxt_gc_pend, tx_second_ff, nxt_tx_second;
   logic sda_oe_ff, nxt_oe, sda_o_ff;
   logic sel_hi_ff, nxt_sel_hi, sel_lo_ff, nxt_sel_lo;
   logic sel_neq_ff, nxt_sel_neq, sel_hi, sel_lo, sel_neq;
   logic own_hit, bcast_hit, gcall_hit;
   reg_write_t wr_word_ff, nxt_wr_word;
   logic wr_commit_ff, nxt_commit, soft_reset_ff, nxt_soft_reset;

   // select pin is classified by what it did across the address byte
   assign sel_hi = sel_hi_ff | sel_s2;
   assign sel_lo = sel_lo_ff | ~sel_s2;
   assign sel_neq = sel_neq_ff | (sel_s2 ^ sda_s2);
   assign sel_now = !sel_hi ? SEL_GND : !sel_lo ? SEL_VDD :
                    !sel_neq ? SEL_SDA : SEL_SCL;
   assign byte_rx = {shift_ff[6:0], sda_s2};
   // ten-bit headers 11110xx never equal any of these
   assign own_hit = shift_ff[6:0] == {ADDR_FIXED_HI, sel_now};
   assign bcast_hit = (shift_ff[6:0] == BCAST_ADDR) & ~sda_s2;
   assign gcall_hit = (shift_ff[6:0] == GCALL_ADDR) & ~sda_s2;

   // ------------------------------------------------------------
   // i2c target sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_bitcnt = bitcnt_ff;
      nxt_shift = shift_ff;
      nxt_tx = tx_ff;
      nxt_cmd = cmd_ff;
      nxt_upper = upper_ff;
      nxt_lower = lower_ff;
      nxt_byte_idx = byte_idx_ff;
      nxt_gcall = gcall_ff;
      nxt_bcast = bcast_ff;
      nxt_rw = rw_ff;
      nxt_gc_pend = gc_pend_ff;
      nxt_tx_second = tx_second_ff;
      nxt_oe = sda_oe_ff;
      nxt_sel_hi = sel_hi_ff;
      nxt_sel_lo = sel_lo_ff;
      nxt_sel_neq = sel_neq_ff;
      nxt_sel_code = sel_code_ff;
      nxt_wr_word = wr_word_ff;
      nxt_commit = 1'b0;
      nxt_soft_reset = 1'b0;
      if (stop)
      begin
         nxt_state = ST_IDLE;
         nxt_oe = 1'b0;
      end
      else if (start)
      begin
         nxt_state = ST_ADDR;
         nxt_bitcnt = 3'h0;
         nxt_oe = 1'b0;
         nxt_sel_hi = 1'b0;
         nxt_sel_lo = 1'b0;
         nxt_sel_neq = 1'b0;
      end
      else
         case (state_ff)
            ST_ADDR:
            begin
               if (scl_rise || scl_fall)
               begin
                  nxt_sel_hi = sel_hi;
                  nxt_sel_lo = sel_lo;
                  nxt_sel_neq = sel_neq;
               end
               if (scl_rise)
               begin
                  nxt_shift = byte_rx;
                  nxt_bitcnt = bitcnt_ff + 3'h1;
                  if (bitcnt_ff == BIT_LAST)
                  begin
                     nxt_sel_code = sel_now;
                     nxt_gcall = gcall_hit;
                     nxt_bcast = bcast_hit;
                     nxt_rw = sda_s2;
                     if (own_hit || bcast_hit || gcall_hit)
                        nxt_state = ST_ADDR_ACK;
                     else
                        nxt_state = ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK:
               if (scl_fall)
               begin
                  if (!sda_oe_ff)
                     nxt_oe = 1'b1;
                  else if (rw_ff)
                  begin
                     nxt_state = ST_RD_BYTE;
                     nxt_tx = rd_data[15:8];
                     nxt_oe = ~rd_data[15];
                     nxt_bitcnt = 3'h0;
                     nxt_tx_second = 1'b0;
                  end
                  else
                  begin
                     nxt_state = ST_WR_BYTE;
                     nxt_oe = 1'b0;
                     nxt_bitcnt = 3'h0;
                     nxt_byte_idx = BYTE_CMD;
                     nxt_gc_pend = 1'b0;
                  end
               end
            ST_WR_BYTE:
               if (scl_rise)
               begin
                  nxt_shift = byte_rx;
                  nxt_bitcnt = bitcnt_ff + 3'h1;
                  if (bitcnt_ff == BIT_LAST)
                  begin
                     nxt_state = ST_WR_ACK;
                     case (byte_idx_ff)
                        BYTE_CMD:
                           if (gcall_ff)
                              nxt_gc_pend = byte_rx == GCALL_RESET_CMD;
                           else
                              nxt_cmd = byte_rx;
                        BYTE_UPPER: nxt_upper = byte_rx;
                        BYTE_LOWER: nxt_lower = byte_rx;
                        default: ;
                     endcase
                  end
               end
            ST_WR_ACK:
            begin
               if (scl_rise && gc_pend_ff)
               begin
                  nxt_soft_reset = 1'b1;
                  nxt_gc_pend = 1'b0;
               end
               if (scl_fall)
               begin
                  if (!sda_oe_ff)
                     nxt_oe = 1'b1;
                  else
                  begin
                     nxt_oe = 1'b0;
                     nxt_state = ST_WR_BYTE;
                     nxt_bitcnt = 3'h0;
                     if (byte_idx_ff == BYTE_LOWER && !gcall_ff)
                     begin
                        nxt_commit = 1'b1;
                        nxt_wr_word.cmd = cmd_ff;
                        nxt_wr_word.upper_data_byte = upper_ff;
                        nxt_wr_word.lower_data_byte = lower_ff;
                     end
                     if (byte_idx_ff != BYTE_EXTRA)
                        nxt_byte_idx = byte_idx_ff + 2'h1;
                  end
               end
            end
            ST_RD_BYTE:
               if (scl_fall)
               begin
                  // data only moves while the clock is low
                  if (bitcnt_ff == BIT_LAST)
                  begin
                     nxt_oe = 1'b0;
                     nxt_state = ST_RD_ACK;
                  end
                  else
                  begin
                     nxt_bitcnt = bitcnt_ff + 3'h1;
                     nxt_tx = {tx_ff[6:0], 1'b1};
                     nxt_oe = ~tx_ff[6];
                  end
               end
            ST_RD_ACK:
               if (scl_rise)
               begin
                  if (sda_s2 || tx_second_ff)
                     nxt_state = ST_IGNORE;
                  else
                  begin
                     nxt_state = ST_RD_NEXT;
                     nxt_tx = rd_data[7:0];
                     nxt_tx_second = 1'b1;
                  end
               end
            ST_RD_NEXT:
               if (scl_fall)
               begin
                  nxt_state = ST_RD_BYTE;
                  nxt_bitcnt = 3'h0;
                  nxt_oe = ~tx_ff[7];
               end
            default: ;
         endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= ST_IDLE;
         bitcnt_ff <= 3'h0;
         shift_ff <= BYTE_RST;
         tx_ff <= BYTE_RST;
         cmd_ff <= BYTE_RST;
         upper_ff <= BYTE_RST;
         lower_ff <= BYTE_RST;
         byte_idx_ff <= BYTE_CMD;
         {gcall_ff, bcast_ff, rw_ff, gc_pend_ff, tx_second_ff} <= 5'h0;
         {sda_oe_ff, sda_o_ff, sel_hi_ff, sel_lo_ff, sel_neq_ff} <= 5'h0;
         sel_code_ff <= SEL_GND;
         wr_word_ff <= '0;
         wr_commit_ff <= 1'b0;
         soft_reset_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         bitcnt_ff <= nxt_bitcnt;
         shift_ff <= nxt_shift;
         tx_ff <= nxt_tx;
         cmd_ff <= nxt_cmd;
         upper_ff <= nxt_upper;
         lower_ff <= nxt_lower;
         byte_idx_ff <= nxt_byte_idx;
         {gcall_ff, bcast_ff, rw_ff} <= {nxt_gcall, nxt_bcast, nxt_rw};
         {gc_pend_ff, tx_second_ff} <= {nxt_gc_pend, nxt_tx_second};
         sda_oe_ff <= nxt_oe;
         sda_o_ff <= 1'b0;
         {sel_hi_ff, sel_lo_ff, sel_neq_ff} <=
            {nxt_sel_hi, nxt_sel_lo, nxt_sel_neq};
         sel_code_ff <= nxt_sel_code;
         wr_word_ff <= nxt_wr_word;
         wr_commit_ff <= nxt_commit;
         soft_reset_ff <= nxt_soft_reset;
      end
   end

   // ------------------------------------------------------------
   // spi shift logic on the link clock
   // ------------------------------------------------------------
   logic [23:0] spi_shift_ff, nxt_spi_shift;
   logic [4:0] spi_pos_ff, nxt_spi_pos;
   logic [SPI_CNT_W-1:0] spi_total_ff, nxt_spi_total;
   logic spi_sdo_ff;

   // counters run free; frames are judged by difference, never cleared
   always_comb
   begin
      nxt_spi_shift = {spi_shift_ff[22:0], spi_sdi};
      nxt_spi_total = spi_total_ff + CNT_ONE;
      if (spi_pos_ff == SPI_POS_LAST)
         nxt_spi_pos = 5'h0;
      else
         nxt_spi_pos = spi_pos_ff + 5'h1;
   end

   always_ff @(posedge spi_sclk or posedge reset)
   begin
      if (reset)
      begin
         spi_shift_ff <= 24'h0;
         spi_pos_ff <= 5'h0;
         spi_total_ff <= '0;
      end
      else
      begin
         spi_shift_ff <= nxt_spi_shift;
         spi_pos_ff <= nxt_spi_pos;
         spi_total_ff <= nxt_spi_total;
      end
   end

   // bit 23 leaves one edge later, so the next device sees a 24-bit delay
   always_ff @(negedge spi_sclk or posedge reset)
   begin
      if (reset)
         spi_sdo_ff <= 1'b0;
      else
         spi_sdo_ff <= spi_shift_ff[23];
   end

   // ------------------------------------------------------------
   // spi frame check in the system domain
   // ------------------------------------------------------------
   // link counters are read only after frame end, when the link clock
   // has stopped; back-to-back frames need four system cycles between
   logic [4:0] last_pos_ff, nxt_last_pos;
   logic [SPI_CNT_W-1:0] last_total_ff, nxt_last_total;
   logic [23:0] spi_word_ff, nxt_spi_word;
   logic spi_valid_ff, nxt_spi_valid, sdo_oe_ff, nxt_sdo_oe, frame_end;

   assign frame_end = sync_s2 & ~sync_s3;

   always_comb
   begin
      nxt_last_pos = last_pos_ff;
      nxt_last_total = last_total_ff;
      nxt_spi_word = spi_word_ff;
      nxt_spi_valid = 1'b0;
      nxt_sdo_oe = serial_out_enable & ~sync_s2;
      if (frame_end)
      begin
         nxt_last_pos = spi_pos_ff;
         nxt_last_total = spi_total_ff;
         if (spi_pos_ff == last_pos_ff && spi_total_ff != last_total_ff)
         begin
            nxt_spi_word = spi_shift_ff;
            nxt_spi_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         last_pos_ff <= 5'h0;
         last_total_ff <= '0;
         spi_word_ff <= 24'h0;
         spi_valid_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
      end
      else
      begin
         last_pos_ff <= nxt_last_pos;
         last_total_ff <= nxt_last_total;
         spi_word_ff <= nxt_spi_word;
         spi_valid_ff <= nxt_spi_valid;
         sdo_oe_ff <= nxt_sdo_oe;
      end
   end

   assign sda_o = sda_o_ff;
   assign sda_oe = sda_oe_ff;
   assign spi_sdo = spi_sdo_ff;
   assign spi_sdo_oe = sdo_oe_ff;
   assign wr_word = wr_word_ff;
   assign wr_commit = wr_commit_ff;
   assign rd_cmd = cmd_ff;
   assign soft_reset = soft_reset_ff;
   assign addr_low = sel_code_ff;
   assign spi_word = spi_word_ff;
   assign spi_word_valid = spi_valid_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_COMMIT_ON_ACK_FALL: assert property (@(posedge sys_clk)
      disable iff (reset) wr_commit_ff |-> $past(scl_fall) &&
      $past(state_ff) == ST_WR_ACK && $past(byte_idx_ff) == BYTE_LOWER)
      else $error("commit outside lower byte acknowledge fall");
   AST_RESET_ON_ACK_RISE: assert property (@(posedge sys_clk)
      disable iff (reset) soft_reset_ff |-> $past(scl_rise) &&
      $past(gcall_ff) && $past(state_ff) == ST_WR_ACK)
      else $error("soft reset outside general call acknowledge");
   AST_STOP_RELEASES: assert property (@(posedge sys_clk)
      disable iff (reset) stop |=> !sda_oe_ff && state_ff == ST_IDLE)
      else $error("stop did not release bus");
   AST_START_TO_ADDR: assert property (@(posedge sys_clk)
      disable iff (reset) start && !stop |=> state_ff == ST_ADDR
      ##1 (bitcnt_ff == 3'h0 || scl_rise))
      else $error("start not detected");
   AST_IGNORE_RELEASED: assert property (@(posedge sys_clk)
      disable iff (reset) state_ff == ST_IGNORE |-> !sda_oe_ff)
      else $error("data driven after address mismatch");
   AST_ACK_HELD_HIGH: assert property (@(posedge sys_clk)
      disable iff (reset) (state_ff == ST_WR_ACK && sda_oe_ff && scl_rise)
      |=> sda_oe_ff throughout (!scl_fall [*1] ##1 1'b1))
      else $error("acknowledge dropped during clock high");
   AST_MISMATCH_IGNORED: assert property (@(posedge sys_clk)
      disable iff (reset) (state_ff == ST_ADDR && scl_rise && !start &&
      !stop && bitcnt_ff == BIT_LAST && shift_ff[6:3] != ADDR_FIXED_HI &&
      shift_ff[6:0] != BCAST_ADDR && shift_ff[6:0] != GCALL_ADDR)
      |=> state_ff == ST_IGNORE)
      else $error("foreign address accepted");
   AST_BCAST_NO_READ: assert property (@(posedge sys_clk)
      disable iff (reset) state_ff == ST_RD_BYTE |-> !bcast_ff && !gcall_ff)
      else $error("read after broadcast address");
   AST_SPI_WHOLE_FRAME: assert property (@(posedge sys_clk)
      disable iff (reset) spi_valid_ff |-> $past(frame_end) &&
      $past(spi_pos_ff) == $past(last_pos_ff) && last_pos_ff == spi_pos_ff)
      else $error("partial spi frame accepted");

endmodule
`default_nettype wire

// file: tb/dac_host_model.sv
/*
 far-side model: i2c controller and spi host, driven by bench calls.
 assumes the bench resolves the open-drain data wire into sda.
*/
`timescale 1ns/1ns
`default_nettype none
module dac_host_model
(
   // clock
   input wire logic sys_clk,
   // i2c side
   output logic scl,
   output logic sda_drv,
   input wire logic sda,
   // spi side
   output logic sclk,
   output logic sync_n,
   output logic sdi
);
   initial
   begin
      {scl, sda_drv, sync_n} = 3'h7;
      {sclk, sdi} = 2'h0;
   end
   // half bit: 5 cycles keeps scl phases above the sync latency
   task automatic hp;
      repeat (5) @(negedge sys_clk);
   endtask
   task automatic start;
      sda_drv = 1'b1;
      hp;
      scl = 1'b1;
      hp;
      sda_drv = 1'b0;
      hp;
      scl = 1'b0;
   endtask
   task automatic stop;
      sda_drv = 1'b0;
      hp;
      scl = 1'b1;
      hp;
      sda_drv = 1'b1;
      hp;
   endtask
   // data moves only while scl low; ackin low acks a read byte
   task automatic xfer(input logic [7:0] tx, input logic ackin,
      output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_drv = tx[i];
         hp;
         scl = 1'b1;
         hp;
         rx[i] = sda;
         scl = 1'b0;
      end
      sda_drv = ackin;
      hp;
      scl = 1'b1;
      hp;
      ack = sda;
      scl = 1'b0;
      hp;
   endtask
   // link clock only runs inside a frame, 80 ns period
   task automatic frame(input logic [71:0] bits, input int n);
      sync_n = 1'b0;
      #130;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = bits[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      sdi = ~sdi;
      #70 sync_n = 1'b1;
      repeat (12) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// file: tb/dac_serial_if_bench.sv
/*
 self-checking bench for the serial interface block.
 assumes dac_host_model as far side and pull-up on the data wire.
*/
`timescale 1ns/1ns
`default_nettype none
module dac_serial_if_bench;
   import dac_if_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, sda_oe, sda_o, sdo, sdo_oe;
   logic scl, sda_drv, sclk, sync_n, sdi, commit, srst, sv;
   logic [1:0] sel = 2'h0;
   logic soe = 1'b1;
   logic [23:0] sdo_cap = 24'h0;
   logic [7:0] rd_cmd, rx;
   logic [2:0] addr_low;
   logic [23:0] spi_word;
   reg_write_t wr_word;
   int num_errors = 0, tests_run = 0, n_wr = 0, n_rst = 0, n_spi = 0;
   wire sda = sda_drv & (~sda_oe | sda_o);
   wire asp = (sel == 2'h0) ? 1'b0 : (sel == 2'h1) ? 1'b1 :
      (sel == 2'h2) ? sda : scl;
   dac_host_model i_dac_host_model (.sys_clk(sys_clk), .scl(scl),
      .sda_drv(sda_drv), .sda(sda), .sclk(sclk), .sync_n(sync_n),
      .sdi(sdi));
   dac_serial_if i_dac_serial_if (.sys_clk(sys_clk), .reset(reset),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .address_select_pin(asp), .spi_sclk(sclk), .spi_sync_n(sync_n),
      .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
      .serial_out_enable(soe), .wr_word(wr_word), .wr_commit(commit),
      .rd_cmd(rd_cmd), .rd_data(16'ha5c3), .soft_reset(srst),
      .addr_low(addr_low), .spi_word(spi_word), .spi_word_valid(sv));
   // ---------------------------------------------------------------
   // clock, pulse counters, checks
   // ---------------------------------------------------------------
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   // pulses are counted mid-cycle, away from the launching edge
   always @(negedge sys_clk)
   begin
      n_wr += (commit === 1'b1);
      n_rst += (srst === 1'b1);
      n_spi += (sv === 1'b1);
   end
   // echo as a next device would see it, gated by the output enable
   always @(posedge sclk)
   begin
      sdo_cap <= {sdo_cap[22:0], sdo & sdo_oe};
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic byt(input logic [7:0] b, input logic e);
      logic a;
      i_dac_host_model.xfer(b, 1'b1, rx, a);
      chk(a, e);
   endtask
   task automatic wr(input logic [7:0] ab, input logic [23:0] w,
      input logic e);
      int n0;
      n0 = n_wr;
      i_dac_host_model.start();
      byt(ab, e);
      byt(w[23:16], e);
      byt(w[15:8], e);
      byt(w[7:0], e);
      i_dac_host_model.stop();
      chk(24'(n_wr - n0), {23'h0, ~e});
      if (!e) chk(wr_word, w);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_select;
      for (int k = 0; k < 4; k++)
      begin
         sel = k[1:0];
         wr({ADDR_FIXED_HI, 1'b0, sel, 1'b0}, 24'h30a1c0 + k, 1'b0);
         chk(addr_low, k[2:0]);
      end
   endtask
   task automatic t_refuse;
      sel = 2'h0;
      wr(8'h98, 24'h111111, 1'b1);
      wr(8'hf0, 24'h222222, 1'b1);
      wr({BCAST_ADDR, 1'b0}, 24'h445566, 1'b0);
      i_dac_host_model.start();
      byt({BCAST_ADDR, 1'b1}, 1'b1);
      i_dac_host_model.stop();
   endtask
   task automatic t_gcall;
      int n0;
      n0 = n_rst;
      i_dac_host_model.start();
      byt(8'h00, 1'b0);
      byt(GCALL_RESET_CMD, 1'b0);
      chk(24'(n_rst - n0), 24'h1);
      i_dac_host_model.stop();
   endtask
   task automatic t_read;
      logic a;
      i_dac_host_model.start();
      byt(8'h90, 1'b0);
      byt(8'h2c, 1'b0);
      i_dac_host_model.start();
      byt(8'h91, 1'b0);
      i_dac_host_model.xfer(8'hff, 1'b0, rx, a);
      chk(rx, 24'ha5);
      i_dac_host_model.xfer(8'hff, 1'b1, rx, a);
      chk(rx, 24'hc3);
      i_dac_host_model.stop();
      chk(rd_cmd, 24'h2c);
   endtask
   task automatic t_spi;
      int n0;
      n0 = n_spi;
      i_dac_host_model.frame(72'h123456, 24);
      chk(spi_word, 24'h123456);
      i_dac_host_model.frame(72'habcdef654321, 48);
      chk(spi_word, 24'h654321);
      chk(sdo_cap, 24'habcdef);
      soe = 1'b0;
      i_dac_host_model.frame(72'h1abcdef, 25);
      soe = 1'b1;
      chk(sdo_cap, 24'h0);
      chk(24'(n_spi - n0), 24'h2);
      chk(spi_word, 24'h654321);
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge sys_clk);
      reset = 1'b0;
      repeat (5) @(negedge sys_clk);
      t_select;
      t_refuse;
      t_gcall;
      t_read;
      t_spi;
      give_verdict;
   end
   // whole run is near 3900 cycles; allow ample margin
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      give_verdict;
   end
endmodule
`default_nettype wire
